// File: sdsr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host controller model: issues commands, steps transfers and collects the record stream
module sdsr_host_model (
  input  wire logic        pclk,
  output logic             cmd_valid,
  output logic      [5:0]  cmd_index,
  output logic             cmd_app,
  output logic      [31:0] cmd_arg,
  output logic             cmd_crc_ok,
  output logic             xfer_step,
  output logic      [31:0] xfer_addr,
  output logic      [3:0]  card_state,
  output logic             ready_for_data,
  output logic             resp_strobe,
  input  wire logic        rec_bit,
  input  wire logic        rec_strobe
);
  localparam logic [5:0] APP_PREFIX = 6'h37;
  logic [511:0] rec_q;
  int           rec_n;

  // Quiet bus at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_index = 6'h00;
    cmd_app = 1'b0;
    cmd_arg = 32'h0000_0000;
    cmd_crc_ok = 1'b1;
    xfer_step = 1'b0;
    xfer_addr = 32'h0000_0000;
    card_state = 4'h0;
    ready_for_data = 1'b0;
    resp_strobe = 1'b0;
    rec_n = 0;
  end

  // Released index and argument carry inverted data so a stale value never looks valid
  task automatic cmd(input logic [5:0] idx, input logic [31:0] arg, input logic app, input logic ok);
    @(posedge pclk);
    cmd_valid <= 1'b1;
    cmd_index <= idx;
    cmd_arg <= arg;
    cmd_app <= app;
    cmd_crc_ok <= ok;
    @(posedge pclk);
    cmd_valid <= 1'b0;
    cmd_index <= ~idx;
    cmd_arg <= ~arg;
  endtask

  // Record request always goes out as prefix, then status command
  task automatic acmd13();
    cmd(APP_PREFIX, 32'h0000_0000, 1'b0, 1'b1);
    cmd(sdsr_pkg::CMD_STATUS, 32'h0000_0000, 1'b1, 1'b1);
  endtask

  task automatic step(input logic [31:0] a);
    @(posedge pclk);
    xfer_step <= 1'b1;
    xfer_addr <= a;
    @(posedge pclk);
    xfer_step <= 1'b0;
    xfer_addr <= ~a;
  endtask

  task automatic set_state(input logic [3:0] s, input logic r);
    @(posedge pclk);
    card_state <= s;
    ready_for_data <= r;
  endtask

  // Status response; one extra edge lets the captured word settle
  task automatic report();
    @(posedge pclk);
    resp_strobe <= 1'b1;
    @(posedge pclk);
    resp_strobe <= 1'b0;
    @(posedge pclk);
  endtask

  // First bit received ends up in the top position
  always @(posedge pclk) begin
    if (rec_strobe) begin
      rec_q <= {rec_q[510:0], rec_bit};
      rec_n <= rec_n + 1;
    end
  end
endmodule
`default_nettype wire

// File: sdsr_pkg.sv
package sdsr_pkg;

  // Register byte addresses on the APB slave
  localparam logic [7:0] ADDR_STATUS     = 8'h00;
  localparam logic [7:0] ADDR_REPORT     = 8'h04;
  localparam logic [7:0] ADDR_CAPACITY   = 8'h08;
  localparam logic [7:0] ADDR_BLK_LIMITS = 8'h0C;
  localparam logic [7:0] ADDR_ALIGN      = 8'h10;
  localparam logic [7:0] ADDR_BLOCK_LEN  = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STAT   = 8'h18;
  localparam logic [7:0] ADDR_IRQ_EN     = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_CLR    = 8'h20;
  localparam logic [1:0] RECORD_REGION   = 2'h1;   // Bytes 0x40..0x7F hold the state record

  // State record geometry
  localparam int RECORD_BITS  = 512;
  localparam int RECORD_WORDS = 16;

  // Card status word layout
  localparam int BIT_RANGE       = 31;
  localparam int BIT_ALIGN       = 30;
  localparam int BIT_BLKLEN      = 29;
  localparam int BIT_ERASE_ORDER = 28;
  localparam int BIT_ERASE_GROUP = 27;
  localparam int BIT_CRC         = 23;
  localparam int BIT_ILLEGAL     = 22;
  localparam int STATE_LSB       = 9;
  localparam int BIT_READY       = 8;

  // Fault vector positions (also interrupt status positions)
  localparam int F_GROUP  = 0;
  localparam int F_ORDER  = 1;
  localparam int F_BLKLEN = 2;
  localparam int F_ALIGN  = 3;
  localparam int F_RANGE  = 4;
  localparam int F_SENT   = 5;
  localparam int IRQ_W    = 6;

  // Values after reset
  localparam logic [31:0] CAPACITY_RST   = 32'h0100_0000;
  localparam logic [11:0] MAX_BLKLEN_RST = 12'h200;
  localparam logic [11:0] MIN_WR_LEN_RST = 12'h200;
  localparam logic [15:0] ALIGN_RST      = 16'h01FF;
  localparam logic [11:0] BLKLEN_RST     = 12'h200;

  // Command indices
  localparam logic [5:0] CMD_STATUS       = 6'h0D;
  localparam logic [5:0] CMD_SET_BLKLEN   = 6'h10;
  localparam logic [5:0] CMD_READ_SINGLE  = 6'h11;
  localparam logic [5:0] CMD_READ_MULTI   = 6'h12;
  localparam logic [5:0] CMD_WRITE_SINGLE = 6'h18;
  localparam logic [5:0] CMD_WRITE_MULTI  = 6'h19;
  localparam logic [5:0] CMD_ERASE_START  = 6'h20;
  localparam logic [5:0] CMD_ERASE_END    = 6'h21;
  localparam logic [5:0] CMD_ERASE        = 6'h26;

  localparam logic [3:0] CARD_STATE_TRAN = 4'h4;

  // Record sender bit period in pclk cycles
  localparam int BIT_DIV_DEFAULT = 4;

  typedef enum logic [1:0] {
    SDSR_ER_IDLE  = 2'b00,
    SDSR_ER_START = 2'b01,
    SDSR_ER_END   = 2'b10
  } sdsr_erase_t;

endpackage

// File: sdsr_record_tx.sv
`timescale 1ns/1ps
`default_nettype none
module sdsr_record_tx #(
  parameter int BIT_DIV = sdsr_pkg::BIT_DIV_DEFAULT
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  input  wire logic [31:0] word_in,
  output logic      [3:0]  word_idx,
  output logic             dat_bit,
  output logic             dat_strobe,
  output logic             active,
  output logic             done
);

  logic [15:0] div_reg;
  logic [8:0]  bit_reg;
  logic        tick;

  // Divider gives one bit slot per BIT_DIV cycles
  assign tick     = active && (div_reg == 16'(BIT_DIV - 1));
  assign word_idx = bit_reg[8:5];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 16'h0000;
    end else if (!active || tick) begin
      div_reg <= 16'h0000;
    end else begin
      div_reg <= div_reg + 16'h0001;
    end
  end

  // Whole record goes out msb of word 0 first, one bit per slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active     <= 1'b0;
      bit_reg    <= 9'h000;
      dat_bit    <= 1'b0;
      dat_strobe <= 1'b0;
      done       <= 1'b0;
    end else begin
      dat_strobe <= tick;
      done       <= 1'b0;
      if (start && !active) begin
        active  <= 1'b1;
        bit_reg <= 9'h000;
      end else if (tick) begin
        dat_bit <= word_in[~bit_reg[4:0]];
        bit_reg <= bit_reg + 9'h001;
        if (bit_reg == 9'(sdsr_pkg::RECORD_BITS - 1)) begin
          active <= 1'b0;
          done   <= 1'b1;
        end
      end
    end
  end

  record_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    start && !active |=> active && bit_reg == 9'h000)
    else $error("record send did not start");

endmodule
`default_nettype wire

// File: sdsr_status.sv
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Flag block length fault on too-large SET_BLKLEN or illegal length for command.
// - Flag alignment fault on misaligned first block or misaligned multi-block step.
// - Flag range fault on out-of-range address or transfer past capacity.
// - Hold a 512-bit SD state record.
// - After app prefix then status command in transfer state, send the whole record as data; refuse it in any other state.
// - Response-detected bits follow the response actually produced.
// - Execution-detected bits set during execution, read by status command.
// - Previous-command bits cleared once a correct command arrives.
// - State bits follow present state; read-clear bits clear once reported.
module sdsr_status #(
  parameter int BIT_DIV = sdsr_pkg::BIT_DIV_DEFAULT
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cmd_valid,
  input  wire logic [5:0]  cmd_index,
  input  wire logic        cmd_app,
  input  wire logic [31:0] cmd_arg,
  input  wire logic        cmd_crc_ok,
  input  wire logic        xfer_step,
  input  wire logic [31:0] xfer_addr,
  input  wire logic [3:0]  card_state,
  input  wire logic        ready_for_data,
  input  wire logic        resp_strobe,
  output logic      [31:0] resp_status,
  output logic             rec_bit,
  output logic             rec_strobe,
  output logic             rec_active,
  output logic             irq
);

  logic [31:0]                  capacity_reg;
  logic [11:0]                  max_len_reg;
  logic [11:0]                  min_wr_reg;
  logic [15:0]                  align_reg;
  logic [11:0]                  blklen_reg;
  logic [31:0]                  rec_mem [sdsr_pkg::RECORD_WORDS];
  logic [4:0]                   err_reg;
  logic                         crc_bad_reg;
  logic                         illegal_reg;
  logic [sdsr_pkg::IRQ_W-1:0]   irq_stat_reg;
  logic [sdsr_pkg::IRQ_W-1:0]   irq_en_reg;
  logic [31:0]                  erase_start_reg;
  sdsr_pkg::sdsr_erase_t        erase_reg;
  logic [4:0]                   fault_set;
  logic [4:0]                   err_clr;
  logic [31:0]                  status_word;
  logic                         is_rw;
  logic                         is_wr;
  logic                         rec_req;
  logic                         rec_start;
  logic                         rec_done;
  logic [3:0]                   rec_idx;
  logic                         acc_phase;
  logic                         wr_take;

  function automatic logic out_of_range(input logic [31:0] addr, input logic [31:0] cap);
    out_of_range = (addr >= cap);
  endfunction

  function automatic logic misaligned(input logic [31:0] addr, input logic [15:0] mask);
    misaligned = ((addr[15:0] & mask) != 16'h0000);
  endfunction

  // Command classification
  assign is_wr   = (cmd_index == sdsr_pkg::CMD_WRITE_SINGLE) || (cmd_index == sdsr_pkg::CMD_WRITE_MULTI);
  assign is_rw   = is_wr || (cmd_index == sdsr_pkg::CMD_READ_SINGLE) || (cmd_index == sdsr_pkg::CMD_READ_MULTI);
  assign rec_req = cmd_valid && cmd_crc_ok && cmd_app && (cmd_index == sdsr_pkg::CMD_STATUS);
  // Record goes out only in transfer state; a request elsewhere is refused
  assign rec_start = rec_req && (card_state == sdsr_pkg::CARD_STATE_TRAN);

  // Fault detection, both at command time and at each multi-block step
  always_comb begin
    fault_set = 5'h00;
    if (cmd_valid && cmd_crc_ok) begin
      if (cmd_index == sdsr_pkg::CMD_SET_BLKLEN) begin
        fault_set[sdsr_pkg::F_BLKLEN] = (cmd_arg > 32'(max_len_reg)) || (cmd_arg == 32'h0000_0000);
      end
      if (is_wr && (blklen_reg < min_wr_reg)) begin
        fault_set[sdsr_pkg::F_BLKLEN] = 1'b1;
      end
      if (is_rw) begin
        fault_set[sdsr_pkg::F_ALIGN] = misaligned(cmd_arg, align_reg);
        fault_set[sdsr_pkg::F_RANGE] = out_of_range(cmd_arg, capacity_reg);
      end
      if (cmd_index == sdsr_pkg::CMD_ERASE_END) begin
        fault_set[sdsr_pkg::F_ORDER] = (erase_reg != sdsr_pkg::SDSR_ER_START);
        fault_set[sdsr_pkg::F_GROUP] = (erase_reg == sdsr_pkg::SDSR_ER_START) && (cmd_arg < erase_start_reg);
      end
      if (cmd_index == sdsr_pkg::CMD_ERASE) begin
        fault_set[sdsr_pkg::F_ORDER] = (erase_reg != sdsr_pkg::SDSR_ER_END);
      end
    end
    if (xfer_step) begin
      // Execution-time detection during multi-block or stream transfers
      fault_set[sdsr_pkg::F_ALIGN] = fault_set[sdsr_pkg::F_ALIGN] | misaligned(xfer_addr, align_reg);
      fault_set[sdsr_pkg::F_RANGE] = fault_set[sdsr_pkg::F_RANGE] | out_of_range(xfer_addr, capacity_reg);
    end
  end

  // Erase sequence tracker; any other command except status aborts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      erase_reg       <= sdsr_pkg::SDSR_ER_IDLE;
      erase_start_reg <= 32'h0000_0000;
    end else if (cmd_valid && cmd_crc_ok) begin
      case (cmd_index)
        sdsr_pkg::CMD_ERASE_START: begin
          erase_reg       <= sdsr_pkg::SDSR_ER_START;
          erase_start_reg <= cmd_arg;
        end
        sdsr_pkg::CMD_ERASE_END: begin
          erase_reg <= fault_set[sdsr_pkg::F_ORDER] || fault_set[sdsr_pkg::F_GROUP] ?
                       sdsr_pkg::SDSR_ER_IDLE : sdsr_pkg::SDSR_ER_END;
        end
        sdsr_pkg::CMD_STATUS: begin
          erase_reg <= erase_reg;
        end
        default: begin
          erase_reg <= sdsr_pkg::SDSR_ER_IDLE;
        end
      endcase
    end
  end

  // Current block length, updated only by a legal SET_BLKLEN
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blklen_reg <= sdsr_pkg::BLKLEN_RST;
    end else if (cmd_valid && cmd_crc_ok && (cmd_index == sdsr_pkg::CMD_SET_BLKLEN) &&
                 !fault_set[sdsr_pkg::F_BLKLEN]) begin
      blklen_reg <= cmd_arg[11:0];
    end
  end

  // Read-clear bits drop once carried by a response; a new set in that cycle wins
  assign err_clr = resp_strobe ? err_reg : 5'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_reg <= 5'h00;
    end else begin
      err_reg <= (err_reg & ~err_clr) | fault_set;
    end
  end

  // Previous-command bits: reflect the last command, so they lag by one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_bad_reg <= 1'b0;
      illegal_reg <= 1'b0;
    end else if (cmd_valid) begin
      crc_bad_reg <= !cmd_crc_ok;
      illegal_reg <= rec_req && !rec_start;
    end
  end

  // Live word: sticky faults plus state bits that track the card as it is now
  assign status_word = {err_reg, 3'b000, crc_bad_reg, illegal_reg, 9'h000,
                        card_state, ready_for_data, 8'h00};

  // The response carries exactly the word sampled when it is produced
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_status <= 32'h0000_0000;
    end else if (resp_strobe) begin
      resp_status <= status_word;
    end
  end

  // APB: one wait state so read data and pready come from flops
  assign acc_phase = psel && penable && !pready;
  assign wr_take   = psel && penable && pready && pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc_phase;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (acc_phase) begin
        if (paddr[7:6] == sdsr_pkg::RECORD_REGION) begin
          prdata <= rec_mem[paddr[5:2]];
        end else begin
          case (paddr)
            sdsr_pkg::ADDR_STATUS:     prdata <= status_word;
            sdsr_pkg::ADDR_REPORT:     prdata <= resp_status;
            sdsr_pkg::ADDR_CAPACITY:   prdata <= capacity_reg;
            sdsr_pkg::ADDR_BLK_LIMITS: prdata <= {4'h0, min_wr_reg, 4'h0, max_len_reg};
            sdsr_pkg::ADDR_ALIGN:      prdata <= {16'h0000, align_reg};
            sdsr_pkg::ADDR_BLOCK_LEN:  prdata <= {20'h00000, blklen_reg};
            sdsr_pkg::ADDR_IRQ_STAT:   prdata <= {26'h0000000, irq_stat_reg};
            sdsr_pkg::ADDR_IRQ_EN:     prdata <= {26'h0000000, irq_en_reg};
            sdsr_pkg::ADDR_IRQ_CLR:    prdata <= 32'h0000_0000;
            default:                   pslverr <= 1'b1;
          endcase
        end
      end
    end
  end

  // Software-written configuration steers the fault checks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capacity_reg <= sdsr_pkg::CAPACITY_RST;
      max_len_reg  <= sdsr_pkg::MAX_BLKLEN_RST;
      min_wr_reg   <= sdsr_pkg::MIN_WR_LEN_RST;
      align_reg    <= sdsr_pkg::ALIGN_RST;
      irq_en_reg   <= '0;
    end else if (wr_take) begin
      case (paddr)
        sdsr_pkg::ADDR_CAPACITY: capacity_reg <= pwdata;
        sdsr_pkg::ADDR_BLK_LIMITS: begin
          max_len_reg <= pwdata[11:0];
          min_wr_reg  <= pwdata[27:16];
        end
        sdsr_pkg::ADDR_ALIGN:  align_reg  <= pwdata[15:0];
        sdsr_pkg::ADDR_IRQ_EN: irq_en_reg <= pwdata[sdsr_pkg::IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Record store; contents are loaded by software, no reset needed for RAM
  always_ff @(posedge pclk) begin
    if (wr_take && (paddr[7:6] == sdsr_pkg::RECORD_REGION)) begin
      rec_mem[paddr[5:2]] <= pwdata;
    end
  end

  // Interrupt status: sticky, set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= '0;
      irq     <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~((wr_take && paddr == sdsr_pkg::ADDR_IRQ_CLR) ?
                      pwdata[sdsr_pkg::IRQ_W-1:0] : '0)) | {rec_done, fault_set};
      irq <= |(irq_stat_reg & irq_en_reg);
    end
  end

  sdsr_record_tx #(
    .BIT_DIV (BIT_DIV)
  ) u_tx (
    .pclk       (pclk),
    .presetn    (presetn),
    .start      (rec_start),
    .word_in    (rec_mem[rec_idx]),
    .word_idx   (rec_idx),
    .dat_bit    (rec_bit),
    .dat_strobe (rec_strobe),
    .active     (rec_active),
    .done       (rec_done)
  );

  blklen_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_valid && cmd_crc_ok && cmd_index == sdsr_pkg::CMD_SET_BLKLEN && cmd_arg > 32'(max_len_reg)
    |=> err_reg[sdsr_pkg::F_BLKLEN] && $stable(blklen_reg))
    else $error("block length fault missed");

  align_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
    xfer_step && misaligned(xfer_addr, align_reg) |=> status_word[sdsr_pkg::BIT_ALIGN])
    else $error("alignment fault missed");

  range_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_valid && cmd_crc_ok && is_rw && cmd_arg >= capacity_reg |=> status_word[sdsr_pkg::BIT_RANGE])
    else $error("range fault missed");

  record_refuse_a: assert property (@(posedge pclk) disable iff (!presetn)
    rec_req && card_state != sdsr_pkg::CARD_STATE_TRAN && !rec_active |=> !rec_active ##0 illegal_reg)
    else $error("record sent outside transfer state");

  resp_capture_a: assert property (@(posedge pclk) disable iff (!presetn)
    resp_strobe |=> resp_status == $past(status_word))
    else $error("response word not captured");

  prev_cmd_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_valid && !cmd_crc_ok |=> crc_bad_reg ##1 (crc_bad_reg || $past(cmd_valid && cmd_crc_ok)))
    else $error("previous command bit wrong");

  read_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    resp_strobe && fault_set == 5'h00 |=> err_reg == 5'h00)
    else $error("reported bits not cleared");

  erase_order_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_valid && cmd_crc_ok && cmd_index == sdsr_pkg::CMD_ERASE && erase_reg != sdsr_pkg::SDSR_ER_END
    |=> err_reg[sdsr_pkg::F_ORDER] && erase_reg == sdsr_pkg::SDSR_ER_IDLE)
    else $error("erase order fault missed");

endmodule
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, cmd_arg, xfer_addr, resp_status, rd;
  logic         cmd_valid, cmd_app, cmd_crc_ok, xfer_step, ready_for_data, resp_strobe;
  logic [5:0]   cmd_index;
  logic [3:0]   card_state;
  logic         rec_bit, rec_strobe, rec_active, irq, er;
  logic [31:0]  words [16];
  int           err_total, checked;
  // Row: step flag, command, argument, faults {range, align, blklen, order, group}
  logic [43:0]  rows [13] = '{
    {1'b0, sdsr_pkg::CMD_ERASE_END, 32'h0000_0000, 5'h02},
    {1'b0, sdsr_pkg::CMD_ERASE, 32'h0000_0000, 5'h02},
    {1'b0, sdsr_pkg::CMD_ERASE_START, 32'h0000_0400, 5'h00},
    {1'b0, sdsr_pkg::CMD_ERASE_END, 32'h0000_0200, 5'h01},
    {1'b0, sdsr_pkg::CMD_SET_BLKLEN, 32'h0000_0800, 5'h04},
    {1'b0, sdsr_pkg::CMD_SET_BLKLEN, 32'h0000_0000, 5'h04},
    {1'b0, sdsr_pkg::CMD_READ_SINGLE, 32'h0000_0001, 5'h08},
    {1'b0, sdsr_pkg::CMD_READ_MULTI, 32'h0100_0000, 5'h10},
    {1'b0, sdsr_pkg::CMD_WRITE_MULTI, 32'h0000_0200, 5'h00},
    {1'b0, sdsr_pkg::CMD_SET_BLKLEN, 32'h0000_0100, 5'h00},
    {1'b0, sdsr_pkg::CMD_WRITE_SINGLE, 32'h0000_0000, 5'h04},
    {1'b1, 6'h00, 32'h0000_0003, 5'h08},
    {1'b1, 6'h00, 32'h0200_0000, 5'h10}};

  sdsr_status #(.BIT_DIV(1)) u_sdsr_status (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_valid(cmd_valid), .cmd_index(cmd_index), .cmd_app(cmd_app), .cmd_arg(cmd_arg),
    .cmd_crc_ok(cmd_crc_ok), .xfer_step(xfer_step), .xfer_addr(xfer_addr),
    .card_state(card_state), .ready_for_data(ready_for_data), .resp_strobe(resp_strobe),
    .resp_status(resp_status), .rec_bit(rec_bit), .rec_strobe(rec_strobe),
    .rec_active(rec_active), .irq(irq));

  sdsr_host_model u_sdsr_host_model (
    .pclk(pclk), .cmd_valid(cmd_valid), .cmd_index(cmd_index), .cmd_app(cmd_app),
    .cmd_arg(cmd_arg), .cmd_crc_ok(cmd_crc_ok), .xfer_step(xfer_step), .xfer_addr(xfer_addr),
    .card_state(card_state), .ready_for_data(ready_for_data), .resp_strobe(resp_strobe),
    .rec_bit(rec_bit), .rec_strobe(rec_strobe));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // APB master; the slave latency is not assumed, only bounded
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    // A slave that never answers ends the run as a failure
    if (pready !== 1'b1) begin
      err_total++;
      end_sim();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic end_sim();
    if (err_total == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    end_sim();
  end

  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    err_total = 0;
    checked = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    chk({resp_status[30:0], irq}, 32'h0000_0000);
    apb(1'b0, sdsr_pkg::ADDR_CAPACITY, 32'h0);
    chk(rd, sdsr_pkg::CAPACITY_RST);
    apb(1'b0, sdsr_pkg::ADDR_BLK_LIMITS, 32'h0);
    chk(rd, {4'h0, sdsr_pkg::MIN_WR_LEN_RST, 4'h0, sdsr_pkg::MAX_BLKLEN_RST});
    apb(1'b0, sdsr_pkg::ADDR_ALIGN, 32'h0);
    chk(rd, {16'h0000, sdsr_pkg::ALIGN_RST});
    apb(1'b1, sdsr_pkg::ADDR_BLOCK_LEN, 32'h0000_0123);
    apb(1'b0, sdsr_pkg::ADDR_BLOCK_LEN, 32'h0);
    chk(rd, {20'h00000, sdsr_pkg::BLKLEN_RST});
    apb(1'b0, 8'h30, 32'h0);
    chk({rd[30:0], er}, 32'h0000_0001);
    for (int w = 0; w < 16; w++) begin
      words[w] = 32'hA5C3_0F01 ^ (32'(w) * 32'h0801_2003);
      apb(1'b1, 8'(32'h40 + 4 * w), words[w]);
    end
    apb(1'b0, 8'h54, 32'h0);
    chk(rd, words[5]);
    // Each row: clear events, fire it, see it live, report it, see it gone
    foreach (rows[i]) begin
      apb(1'b1, sdsr_pkg::ADDR_IRQ_CLR, 32'h0000_003F);
      if (rows[i][43])
        u_sdsr_host_model.step(rows[i][36:5]);
      else
        u_sdsr_host_model.cmd(rows[i][42:37], rows[i][36:5], 1'b0, 1'b1);
      apb(1'b0, sdsr_pkg::ADDR_STATUS, 32'h0);
      chk(32'(rd[31:27]), 32'(rows[i][4:0]));
      apb(1'b0, sdsr_pkg::ADDR_IRQ_STAT, 32'h0);
      chk(32'(rd[4:0]), 32'(rows[i][4:0]));
      u_sdsr_host_model.report();
      chk(32'(resp_status[31:27]), 32'(rows[i][4:0]));
      apb(1'b0, sdsr_pkg::ADDR_STATUS, 32'h0);
      chk(32'(rd[31:27]), 32'h0);
    end
    apb(1'b0, sdsr_pkg::ADDR_BLOCK_LEN, 32'h0);
    chk(rd, 32'h0000_0100);
    // Last report held the range fault of the final row, state 0, not ready
    apb(1'b0, sdsr_pkg::ADDR_REPORT, 32'h0);
    chk(rd, 32'h8000_0000);
    // A smaller capacity written by software must steer the range check
    apb(1'b1, sdsr_pkg::ADDR_CAPACITY, 32'h0000_1000);
    u_sdsr_host_model.step(32'h0000_1000);
    apb(1'b0, sdsr_pkg::ADDR_STATUS, 32'h0);
    chk(32'(rd[31:27]), 32'h10);
    // Bad CRC, then a refused record request outside transfer state
    u_sdsr_host_model.cmd(sdsr_pkg::CMD_READ_SINGLE, 32'h0000_0200, 1'b0, 1'b0);
    apb(1'b0, sdsr_pkg::ADDR_STATUS, 32'h0);
    chk(32'(rd[23:22]), 32'h2);
    u_sdsr_host_model.set_state(4'h3, 1'b0);
    u_sdsr_host_model.acmd13();
    apb(1'b0, sdsr_pkg::ADDR_STATUS, 32'h0);
    chk({rd[23:22], rd[12:8], rec_active}, 32'h4C);
    u_sdsr_host_model.set_state(sdsr_pkg::CARD_STATE_TRAN, 1'b1);
    u_sdsr_host_model.acmd13();
    apb(1'b0, sdsr_pkg::ADDR_STATUS, 32'h0);
    chk({rd[23:22], rd[12:8], rec_active}, 32'h13);
    u_sdsr_host_model.acmd13();
    for (int k = 0; k < 2000 && rec_active !== 1'b0; k++) @(posedge pclk);
    if (rec_active !== 1'b0) begin
      err_total++;
      end_sim();
    end
    // The last strobe is counted by the model one edge after the send ends
    @(posedge pclk);
    chk(32'(u_sdsr_host_model.rec_n), 32'd512);
    for (int w = 0; w < 16; w++) chk(u_sdsr_host_model.rec_q[511 - 32 * w -: 32], words[w]);
    apb(1'b0, sdsr_pkg::ADDR_IRQ_STAT, 32'h0);
    chk(32'(rd[sdsr_pkg::F_SENT]), 32'h1);
    // Interrupt raised, masked, unmasked and cleared
    apb(1'b1, sdsr_pkg::ADDR_IRQ_CLR, 32'h0000_003F);
    apb(1'b1, sdsr_pkg::ADDR_IRQ_EN, 32'h0000_0004);
    u_sdsr_host_model.cmd(sdsr_pkg::CMD_SET_BLKLEN, 32'h0000_0000, 1'b0, 1'b1);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h1);
    apb(1'b1, sdsr_pkg::ADDR_IRQ_EN, 32'h0000_0000);
    apb(1'b0, sdsr_pkg::ADDR_IRQ_STAT, 32'h0);
    chk({rd[30:0], irq}, 32'h0000_0008);
    apb(1'b1, sdsr_pkg::ADDR_IRQ_EN, 32'h0000_0004);
    apb(1'b1, sdsr_pkg::ADDR_IRQ_CLR, 32'h0000_0004);
    apb(1'b0, sdsr_pkg::ADDR_IRQ_CLR, 32'h0);
    chk({rd[30:0], irq}, 32'h0000_0000);
    end_sim();
  end
endmodule
`default_nettype wire
